/* File: src/bcs_defs.vh */
// constants for the battery charge state machine
`ifndef BCS_DEFS_VH
`define BCS_DEFS_VH

// clock period in ns
`define BCS_CLK_PERIOD_NS 10
// status debounce time in ns and its cycle count (least time, round up)
`define BCS_DEB_TIME_NS 30000
`define BCS_DEB_CYC ((`BCS_DEB_TIME_NS + `BCS_CLK_PERIOD_NS - 1) / `BCS_CLK_PERIOD_NS)
// termination time in ns and its cycle count (least time, round up)
`define BCS_TERM_TIME_NS 20000
`define BCS_TERM_CYC ((`BCS_TERM_TIME_NS + `BCS_CLK_PERIOD_NS - 1) / `BCS_CLK_PERIOD_NS)

// register byte offsets
`define BCS_ADR_CTRL 5'h00
`define BCS_ADR_TIME 5'h04
`define BCS_ADR_ITGT 5'h08
`define BCS_ADR_KICK 5'h0c
`define BCS_ADR_STAT 5'h10

// control field positions
`define BCS_CTRL_CHGEN 0
`define BCS_CTRL_WDEN 1
// status field positions
`define BCS_STAT_OK 4
`define BCS_STAT_STATE_LO 8

// reset values
`define BCS_CHGEN_RST 1'b0
`define BCS_WDEN_RST 1'b0
`define BCS_FCLIM_RST 16'h2a30
`define BCS_TOLIM_RST 16'h0258
`define BCS_ITGT_RST 8'h32
`define BCS_KICK_VAL 8'h01

// reported detail codes
`define BCS_DTL_DEAD 4'h0
`define BCS_DTL_LOWPQ 4'h0
`define BCS_DTL_CC 4'h1
`define BCS_DTL_CV 4'h2
`define BCS_DTL_TOP 4'h3
`define BCS_DTL_DONE 4'h4
`define BCS_DTL_TFAULT 4'h6
`define BCS_DTL_DIS 4'h8
`define BCS_DTL_TSHDN 4'ha
`define BCS_DTL_WDSUSP 4'hb

`endif

/* File: src/bcs_charge_fsm.v */
// battery charge state machine with wishbone register slave
//
// Notes on behaviour
// - charger off or input invalid forces disabled, except in thermal shutdown
// - disabled: zero current, both timers held zero
// - leave disabled only when input valid, enabled, or into thermal shutdown
// - below dead threshold: dead prequal, report 0x00
// - above dead threshold advances to low prequal
// - prequal state over time limit gives timer fault
// - unserviced enabled watchdog gives watchdog suspend
// - between low threshold and regulation: CC, 0x01
// - current capped by target and external limit
// - above regulation voltage advances CC to CV
// - CV holds regulation, reports 0x02 after debounce
// - one fast charge limit spans CC and CV
// - top-off only from CV after termination time
// - top-off lasts programmed duration, then done
// - top-off or done below restart returns CC
// - done reports 0x04, ok cleared, after debounce
// - done commands zero current, no soft start
// - timer fault reports 0x06 at once, charging off
// - enable toggled off then on leaves timer fault
// - input removed and reapplied leaves timer fault
// - kick value 0x01 restarts watchdog and charging
// - thermal shutdown reports 0x0a, pauses, resumes
`timescale 1ns/10ps
`default_nettype none
`include "bcs_defs.vh"

module bcs_charge_fsm #(
  parameter integer TICK_CYCLES = 100000000,
  parameter integer WD_CYCLES = 100000000,
  parameter integer PQ_TICKS = 1800,
  parameter [7:0] DEAD_CURRENT = 8'h04,
  parameter [7:0] LOWPQ_CURRENT = 8'h10
) (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [4:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // comparator and power stage inputs, asynchronous
  input wire primaryPowerInputValid,
  input wire battBelowDeadThreshold,
  input wire battAboveLowThreshold,
  input wire battAboveRegulationVoltage,
  input wire battBelowRestartMargin,
  input wire chargeBelowTerminationCurrent,
  input wire thermalShutdown,
  // combined limit from input limit, foldback and system load
  input wire [7:0] externalCurrentLimit,
  // charge control and status
  output reg [7:0] chargeCurrentCmd,
  output reg deadBattCurrentSelect,
  output reg chargingOn,
  output reg [3:0] chargerStateDetail,
  output reg chargerOkFlag,
  output reg chargerEventIrq
);

  // state codes
  localparam [3:0] ST_DIS = 4'h0;
  localparam [3:0] ST_DEAD = 4'h1;
  localparam [3:0] ST_LOWPQ = 4'h2;
  localparam [3:0] ST_CC = 4'h3;
  localparam [3:0] ST_CV = 4'h4;
  localparam [3:0] ST_TOP = 4'h5;
  localparam [3:0] ST_DONE = 4'h6;
  localparam [3:0] ST_TFAULT = 4'h7;
  localparam [3:0] ST_WDSUSP = 4'h8;
  localparam [3:0] ST_TSHDN = 4'h9;

  localparam [31:0] DEB_CYC = `BCS_DEB_CYC;
  localparam [31:0] TERM_CYC = `BCS_TERM_CYC;

  // smaller of target and outside limit
  function [7:0] minCur;
    input [7:0] a;
    input [7:0] b;
    begin
      minCur = (a < b) ? a : b;
    end
  endfunction

  // first charging state picked from battery level
  function [3:0] entryState;
    input belowDead;
    input aboveLow;
    input aboveReg;
    begin
      if (belowDead) begin
        entryState = ST_DEAD;
      end else if (!aboveLow) begin
        entryState = ST_LOWPQ;
      end else if (!aboveReg) begin
        entryState = ST_CC;
      end else begin
        entryState = ST_CV;
      end
    end
  endfunction

  // two flop synchroniser for the asynchronous inputs
  reg [6:0] syncA_reg;
  reg [6:0] syncB_reg;
  always @(posedge ref_clk) begin
    if (!nrst) begin
      syncA_reg <= 7'h00;
      syncB_reg <= 7'h00;
    end else begin
      syncA_reg <= {thermalShutdown, chargeBelowTerminationCurrent,
                    battBelowRestartMargin, battAboveRegulationVoltage,
                    battAboveLowThreshold, battBelowDeadThreshold,
                    primaryPowerInputValid};
      syncB_reg <= syncA_reg;
    end
  end
  wire inValid = syncB_reg[0];
  wire belowDead = syncB_reg[1];
  wire aboveLow = syncB_reg[2];
  wire aboveReg = syncB_reg[3];
  wire belowRestart = syncB_reg[4];
  wire belowTerm = syncB_reg[5];
  wire thermHot = syncB_reg[6];

  // control registers
  reg chgEnable_reg;
  reg wdEnable_reg;
  reg [15:0] fastChargeTimeLimit_reg;
  reg [15:0] topoffDuration_reg;
  reg [7:0] currentTarget_reg;
  reg wdKick;

  // state registers
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [3:0] resume_reg;
  reg [31:0] tickCnt_reg;
  reg [15:0] stateTimer_reg;
  reg [15:0] fcTimer_reg;
  reg [31:0] wdCnt_reg;
  reg [31:0] termCnt_reg;
  reg [31:0] debCnt_reg;
  reg reported_reg;

  // wishbone access: commit at the edge where ack is seen high
  wire wbReq = wb_cyc_i & wb_stb_i;
  wire wbCommit = wbReq & wb_ack_o & wb_we_i;
  always @(posedge ref_clk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wbReq & ~wb_ack_o;
      if (wbReq & ~wb_ack_o & ~wb_we_i) begin
        case (wb_adr_i)
          `BCS_ADR_CTRL: wb_dat_o <= {30'h00000000, wdEnable_reg,
                                      chgEnable_reg};
          `BCS_ADR_TIME: wb_dat_o <= {topoffDuration_reg,
                                      fastChargeTimeLimit_reg};
          `BCS_ADR_ITGT: wb_dat_o <= {24'h000000, currentTarget_reg};
          `BCS_ADR_STAT: wb_dat_o <= {20'h00000,
                                      state_reg, 3'h0, chargerOkFlag,
                                      chargerStateDetail};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // control register writes, byte lanes honoured
  always @(posedge ref_clk) begin
    if (!nrst) begin
      chgEnable_reg <= `BCS_CHGEN_RST;
      wdEnable_reg <= `BCS_WDEN_RST;
      fastChargeTimeLimit_reg <= `BCS_FCLIM_RST;
      topoffDuration_reg <= `BCS_TOLIM_RST;
      currentTarget_reg <= `BCS_ITGT_RST;
      wdKick <= 1'b0;
    end else begin
      wdKick <= 1'b0;
      if (wbCommit) begin
        case (wb_adr_i)
          `BCS_ADR_CTRL: begin
            if (wb_sel_i[0]) begin
              chgEnable_reg <= wb_dat_i[`BCS_CTRL_CHGEN];
              wdEnable_reg <= wb_dat_i[`BCS_CTRL_WDEN];
            end
          end
          `BCS_ADR_TIME: begin
            if (wb_sel_i[0]) fastChargeTimeLimit_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) fastChargeTimeLimit_reg[15:8] <= wb_dat_i[15:8];
            if (wb_sel_i[2]) topoffDuration_reg[7:0] <= wb_dat_i[23:16];
            if (wb_sel_i[3]) topoffDuration_reg[15:8] <= wb_dat_i[31:24];
          end
          `BCS_ADR_ITGT: begin
            if (wb_sel_i[0]) currentTarget_reg <= wb_dat_i[7:0];
          end
          `BCS_ADR_KICK: begin
            // kick only on the exact value
            if (wb_sel_i[0] && wb_dat_i[7:0] == `BCS_KICK_VAL) begin
              wdKick <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // derived conditions
  wire chargeAllowed = chgEnable_reg & inValid;
  wire inPrequal = (state_reg == ST_DEAD) | (state_reg == ST_LOWPQ);
  wire inFast = (state_reg == ST_CC) | (state_reg == ST_CV);
  wire wdWatched = inPrequal | inFast | (state_reg == ST_TOP) |
                   (state_reg == ST_DONE) | (state_reg == ST_TFAULT);
  wire wdExpired = wdEnable_reg & (wdCnt_reg >= WD_CYCLES - 1);
  wire pqExpired = stateTimer_reg >= PQ_TICKS[15:0];
  wire fcExpired = (fastChargeTimeLimit_reg != 16'h0000) &
                   (fcTimer_reg >= fastChargeTimeLimit_reg);
  wire tick = (tickCnt_reg == TICK_CYCLES - 1);

  // next state
  always @* begin
    state_next = state_reg;
    if (thermHot && state_reg != ST_TSHDN) begin
      state_next = ST_TSHDN;
    end else if (state_reg == ST_TSHDN) begin
      if (!thermHot) state_next = resume_reg;
    end else if (!chargeAllowed) begin
      state_next = ST_DIS;
    end else if (wdWatched && wdExpired) begin
      state_next = ST_WDSUSP;
    end else begin
      case (state_reg)
        ST_DIS: state_next = entryState(belowDead, aboveLow, aboveReg);
        ST_DEAD: begin
          if (pqExpired) state_next = ST_TFAULT;
          else if (!belowDead) state_next = ST_LOWPQ;
        end
        ST_LOWPQ: begin
          if (pqExpired) state_next = ST_TFAULT;
          else if (aboveLow) state_next = ST_CC;
        end
        ST_CC: begin
          if (fcExpired) state_next = ST_TFAULT;
          else if (aboveReg) state_next = ST_CV;
        end
        ST_CV: begin
          if (fcExpired) state_next = ST_TFAULT;
          else if (termCnt_reg >= TERM_CYC) state_next = ST_TOP;
        end
        ST_TOP: begin
          if (belowRestart) state_next = ST_CC;
          else if (stateTimer_reg >= topoffDuration_reg) begin
            state_next = ST_DONE;
          end
        end
        ST_DONE: begin
          if (belowRestart) state_next = ST_CC;
        end
        ST_TFAULT: state_next = ST_TFAULT;
        ST_WDSUSP: begin
          if (wdKick) begin
            state_next = entryState(belowDead, aboveLow, aboveReg);
          end
        end
        default: state_next = ST_DIS;
      endcase
    end
  end

  wire changing = state_next != state_reg;
  wire thermalHop = (state_next == ST_TSHDN) | (state_reg == ST_TSHDN);

  // state, saved state and timers
  always @(posedge ref_clk) begin
    if (!nrst) begin
      state_reg <= ST_DIS;
      resume_reg <= ST_DIS;
      tickCnt_reg <= 32'h00000000;
      stateTimer_reg <= 16'h0000;
      fcTimer_reg <= 16'h0000;
      wdCnt_reg <= 32'h00000000;
      termCnt_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      if (state_next == ST_TSHDN && state_reg != ST_TSHDN) begin
        resume_reg <= state_reg;
      end
      // timebase stands still in thermal shutdown
      if (state_reg != ST_TSHDN) begin
        tickCnt_reg <= tick ? 32'h00000000 : tickCnt_reg + 32'h00000001;
      end
      // per state timer for prequal and top-off
      if (state_reg == ST_DIS || (changing && !thermalHop)) begin
        stateTimer_reg <= 16'h0000;
      end else if (tick && (inPrequal || state_reg == ST_TOP)) begin
        stateTimer_reg <= stateTimer_reg + 16'h0001;
      end
      // fast charge timer shared by CC and CV
      if (!inFast && state_reg != ST_TSHDN) begin
        fcTimer_reg <= 16'h0000;
      end else if (tick && inFast && fcTimer_reg != 16'hffff) begin
        fcTimer_reg <= fcTimer_reg + 16'h0001;
      end
      // watchdog counter
      if (state_reg == ST_DIS || !wdEnable_reg || wdKick ||
          state_reg == ST_WDSUSP) begin
        wdCnt_reg <= 32'h00000000;
      end else if (wdWatched && !wdExpired) begin
        wdCnt_reg <= wdCnt_reg + 32'h00000001;
      end
      // termination qualification in CV
      if (state_reg == ST_CV && belowTerm && !changing) begin
        if (termCnt_reg < TERM_CYC) begin
          termCnt_reg <= termCnt_reg + 32'h00000001;
        end
      end else begin
        termCnt_reg <= 32'h00000000;
      end
    end
  end

  // status code and ok level for each state
  reg [3:0] codeNow;
  reg okNow;
  reg instantNow;
  always @* begin
    codeNow = `BCS_DTL_DIS;
    okNow = 1'b1;
    instantNow = 1'b0;
    case (state_reg)
      ST_DIS: codeNow = `BCS_DTL_DIS;
      ST_DEAD: codeNow = `BCS_DTL_DEAD;
      ST_LOWPQ: codeNow = `BCS_DTL_LOWPQ;
      ST_CC: codeNow = `BCS_DTL_CC;
      ST_CV: codeNow = `BCS_DTL_CV;
      ST_TOP: codeNow = `BCS_DTL_TOP;
      ST_DONE: begin
        codeNow = `BCS_DTL_DONE;
        okNow = 1'b0;
      end
      ST_TFAULT: begin
        codeNow = `BCS_DTL_TFAULT;
        okNow = 1'b0;
        instantNow = 1'b1;
      end
      ST_WDSUSP: begin
        codeNow = `BCS_DTL_WDSUSP;
        okNow = 1'b0;
        instantNow = 1'b1;
      end
      ST_TSHDN: begin
        codeNow = `BCS_DTL_TSHDN;
        okNow = 1'b0;
        instantNow = 1'b1;
      end
      default: codeNow = `BCS_DTL_DIS;
    endcase
  end

  // debounced status report and event pulse
  wire reportNow = !reported_reg && !changing &&
                   (instantNow || debCnt_reg >= DEB_CYC - 1);
  always @(posedge ref_clk) begin
    if (!nrst) begin
      debCnt_reg <= 32'h00000000;
      reported_reg <= 1'b0;
      chargerStateDetail <= `BCS_DTL_DIS;
      chargerOkFlag <= 1'b0;
      chargerEventIrq <= 1'b0;
    end else begin
      chargerEventIrq <= 1'b0;
      if (changing) begin
        debCnt_reg <= 32'h00000000;
        reported_reg <= 1'b0;
      end else if (reportNow) begin
        reported_reg <= 1'b1;
        chargerStateDetail <= codeNow;
        chargerOkFlag <= okNow;
        chargerEventIrq <= 1'b1;
      end else if (!reported_reg) begin
        debCnt_reg <= debCnt_reg + 32'h00000001;
      end
    end
  end

  // commanded current, never above target or outside limit
  always @(posedge ref_clk) begin
    if (!nrst) begin
      chargeCurrentCmd <= 8'h00;
      deadBattCurrentSelect <= 1'b0;
      chargingOn <= 1'b0;
    end else begin
      deadBattCurrentSelect <= (state_next == ST_DEAD);
      case (state_next)
        ST_DEAD: begin
          chargeCurrentCmd <= minCur(minCur(DEAD_CURRENT, currentTarget_reg),
                                     externalCurrentLimit);
          chargingOn <= 1'b1;
        end
        ST_LOWPQ: begin
          chargeCurrentCmd <= minCur(minCur(LOWPQ_CURRENT, currentTarget_reg),
                                     externalCurrentLimit);
          chargingOn <= 1'b1;
        end
        ST_CC, ST_CV, ST_TOP: begin
          // full step on restart from done, no ramp
          chargeCurrentCmd <= minCur(currentTarget_reg,
                                     externalCurrentLimit);
          chargingOn <= 1'b1;
        end
        default: begin
          chargeCurrentCmd <= 8'h00;
          chargingOn <= 1'b0;
        end
      endcase
    end
  end

endmodule // bcs_charge_fsm
`default_nettype wire

/* File: tb/bcs_power_stage_model.sv */
// power stage and comparator model facing the charge state machine
`timescale 1ns/10ps
`default_nettype none
module bcs_power_stage_model #(
  parameter [7:0] DEAD_V = 8'h14,
  parameter [7:0] LOW_V = 8'h1e,
  parameter [7:0] REG_V = 8'h2a,
  parameter [7:0] RST_V = 8'h28,
  parameter [7:0] TERM_I = 8'h08
) (
  // clock
  input wire logic ref_clk,
  // bench controls: cell voltage and supply headroom
  input wire logic [7:0] battVolt,
  input wire logic [7:0] sysAvail,
  // device side
  input wire logic [7:0] chargeCurrentCmd,
  input wire logic chargingOn,
  output logic battBelowDeadThreshold,
  output logic battAboveLowThreshold,
  output logic battAboveRegulationVoltage,
  output logic battBelowRestartMargin,
  output logic chargeBelowTerminationCurrent,
  output logic [7:0] externalCurrentLimit
);
  logic [6:0] slowDiv = 7'h00;
  logic [7:0] battCurrent = 8'h00;
  // comparator levels from the cell voltage
  assign battBelowDeadThreshold = battVolt < DEAD_V;
  assign battAboveLowThreshold = battVolt > LOW_V;
  assign battAboveRegulationVoltage = battVolt > REG_V;
  assign battBelowRestartMargin = battVolt < RST_V;
  // system load is served first, the charger gets what is left
  assign externalCurrentLimit = sysAvail;
  assign chargeBelowTerminationCurrent = battCurrent < TERM_I;
  // cell current follows the command, then sags slowly at regulation
  always @(posedge ref_clk) begin
    slowDiv <= slowDiv + 7'h01;
    if (!chargingOn)
      battCurrent <= 8'h00;
    else if (!battAboveRegulationVoltage)
      battCurrent <= chargeCurrentCmd;
    else if (slowDiv == 7'h00 && battCurrent != 8'h00)
      battCurrent <= battCurrent - 8'h01;
  end
endmodule // bcs_power_stage_model
`default_nettype wire

/* File: tb/bcs_charge_fsm_chk.sv */
// port checker for the battery charge state machine
`timescale 1ns/10ps
`default_nettype none
module bcs_charge_fsm_chk #(
  parameter [7:0] DEAD_CURRENT = 8'h04
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // watched inputs
  input wire logic primaryPowerInputValid,
  input wire logic thermalShutdown,
  input wire logic [7:0] externalCurrentLimit,
  // watched outputs
  input wire logic [7:0] chargeCurrentCmd,
  input wire logic deadBattCurrentSelect,
  input wire logic chargingOn,
  input wire logic [3:0] chargerStateDetail,
  input wire logic chargerOkFlag,
  input wire logic chargerEventIrq
);
  // one clock domain, reset masks every check
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  input_off_a: assert property (
    !primaryPowerInputValid [*6] |->
    chargeCurrentCmd == 8'h00 && !chargingOn)
    else $error("current while input invalid");
  detail_irq_a: assert property (
    $changed(chargerStateDetail) || $changed(chargerOkFlag) |->
    chargerEventIrq) else $error("status moved without event");
  ok_code_a: assert property (
    chargerEventIrq |-> chargerOkFlag ==
    (chargerStateDetail inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h8}))
    else $error("ok flag wrong for code");
  done_zero_a: assert property (
    chargerEventIrq && chargerStateDetail == 4'h4 |->
    chargeCurrentCmd == 8'h00 && !chargingOn)
    else $error("current in done");
  cur_cap_a: assert property (
    (chargingOn && $stable(externalCurrentLimit)) [*3] |->
    chargeCurrentCmd <= externalCurrentLimit)
    else $error("current above limit");
  dead_cur_a: assert property (
    deadBattCurrentSelect |-> chargingOn &&
    chargeCurrentCmd <= DEAD_CURRENT) else $error("dead current wrong");
  fault_fast_a: assert property (
    chargerEventIrq && chargerStateDetail == 4'h6 |-> !chargingOn &&
    ($past(chargingOn) || $past(chargingOn, 2)))
    else $error("timer fault report late");
  therm_fast_a: assert property (
    $rose(thermalShutdown) |->
    ##[1:8] chargerEventIrq && chargerStateDetail == 4'ha)
    else $error("thermal report late");
  dis_report_a: assert property (
    chargerEventIrq && chargerStateDetail == 4'h8 |->
    chargeCurrentCmd == 8'h00 && !chargingOn)
    else $error("current while disabled");
endmodule // bcs_charge_fsm_chk
bind bcs_charge_fsm bcs_charge_fsm_chk #(.DEAD_CURRENT(DEAD_CURRENT))
  i_bcs_charge_fsm_chk (.ref_clk(ref_clk), .nrst(nrst),
  .primaryPowerInputValid(primaryPowerInputValid),
  .thermalShutdown(thermalShutdown),
  .externalCurrentLimit(externalCurrentLimit),
  .chargeCurrentCmd(chargeCurrentCmd),
  .deadBattCurrentSelect(deadBattCurrentSelect), .chargingOn(chargingOn),
  .chargerStateDetail(chargerStateDetail), .chargerOkFlag(chargerOkFlag),
  .chargerEventIrq(chargerEventIrq));
`default_nettype wire

/* File: tb/tb_bcs_charge_fsm.sv */
// self-checking bench for the battery charge state machine
`timescale 1ns/10ps
`default_nettype none
module tb_bcs_charge_fsm;
  logic ref_clk, wb_ack_o, battBelowDeadThreshold, battAboveLowThreshold;
  logic nrst, wb_cyc_i, wb_stb_i, wb_we_i;
  logic primaryPowerInputValid, thermalShutdown;
  logic battAboveRegulationVoltage, battBelowRestartMargin;
  logic chargeBelowTerminationCurrent, deadBattCurrentSelect, chargingOn;
  logic chargerOkFlag, chargerEventIrq;
  logic [4:0] wb_adr_i;
  logic [3:0] wb_sel_i, sel, chargerStateDetail;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0] externalCurrentLimit, chargeCurrentCmd, tgt;
  logic [7:0] battVolt, sysAvail;
  logic [4:0] expRep[$];
  logic [31:0] expRd[$];
  integer errors = 0, compares = 0, seed = 32'hf8038dd0, n;

  bcs_charge_fsm #(.TICK_CYCLES(10), .WD_CYCLES(200), .PQ_TICKS(400))
    i_bcs_charge_fsm (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .primaryPowerInputValid(primaryPowerInputValid),
    .battBelowDeadThreshold(battBelowDeadThreshold),
    .battAboveLowThreshold(battAboveLowThreshold),
    .battAboveRegulationVoltage(battAboveRegulationVoltage),
    .battBelowRestartMargin(battBelowRestartMargin),
    .chargeBelowTerminationCurrent(chargeBelowTerminationCurrent),
    .thermalShutdown(thermalShutdown),
    .externalCurrentLimit(externalCurrentLimit),
    .chargeCurrentCmd(chargeCurrentCmd),
    .deadBattCurrentSelect(deadBattCurrentSelect), .chargingOn(chargingOn),
    .chargerStateDetail(chargerStateDetail), .chargerOkFlag(chargerOkFlag),
    .chargerEventIrq(chargerEventIrq));
  bcs_power_stage_model i_bcs_power_stage_model (.ref_clk(ref_clk),
    .battVolt(battVolt), .sysAvail(sysAvail),
    .chargeCurrentCmd(chargeCurrentCmd), .chargingOn(chargingOn),
    .battBelowDeadThreshold(battBelowDeadThreshold),
    .battAboveLowThreshold(battAboveLowThreshold),
    .battAboveRegulationVoltage(battAboveRegulationVoltage),
    .battBelowRestartMargin(battBelowRestartMargin),
    .chargeBelowTerminationCurrent(chargeBelowTerminationCurrent),
    .externalCurrentLimit(externalCurrentLimit));

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task fail(input string msg);
    errors++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask
  task chk_report(input logic [4:0] got, input logic [4:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("report %h, want %h", got, exp));
  endtask
  task chk_read(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("read %h, want %h", got, exp));
  endtask
  task chk_cur(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("current %h, want %h", got, exp));
  endtask
  task finish_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic [7:0] lo(input logic [7:0] a, input logic [7:0] b);
    return a < b ? a : b;
  endfunction
  task cyc(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  // classic single wishbone cycle, waits for ack
  task wb(input logic we, input logic [4:0] adr, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) fail("bus timeout");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task rd(input logic [4:0] adr, input logic [31:0] exp);
    expRd.push_back(exp);
    wb(1'b0, adr, 32'h0);
  endtask
  // bounded wait until every noted report has appeared
  task wait_rep(input int lim);
    int k;
    for (k = 0; k < lim && expRep.size() != 0; k++) @(posedge ref_clk);
    if (expRep.size() != 0) fail("report missing");
    expRep.delete();
  endtask

  // read data monitor
  always @(posedge ref_clk)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expRd.size() != 0)
      chk_read(wb_dat_o, expRd.pop_front());
  // status event monitor
  always @(posedge ref_clk)
    if (chargerEventIrq === 1'b1 && expRep.size() == 0)
      fail("unexpected report");
    else if (chargerEventIrq === 1'b1)
      chk_report({chargerOkFlag, chargerStateDetail}, expRep.pop_front());

  // hang guard
  initial begin
    cyc(90000);
    fail("timeout");
    finish_test;
  end

  initial begin
    nrst <= 1'b0;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    wb_adr_i <= 5'h00;
    wb_sel_i <= 4'hf;
    wb_dat_i <= 32'h0;
    sel = 4'hf;
    primaryPowerInputValid <= 1'b1;
    thermalShutdown <= 1'b0;
    battVolt <= 8'h0a;
    sysAvail <= 8'hff;
    cyc(10);
    nrst <= 1'b1;
    chk_report({chargerOkFlag, chargerStateDetail}, 5'h08);
    rd(5'h00, 32'h0);
    rd(5'h04, 32'h02582a30);
    rd(5'h08, 32'h32);
    rd(5'h0c, 32'h0);
    rd(5'h02, 32'h0);
    rd(5'h10, 32'h8);
    // byte lanes: each half of the time word written alone
    sel = 4'h3;
    wb(1'b1, 5'h04, 32'hffff0000);
    sel = 4'hc;
    wb(1'b1, 5'h04, {16'd400, 16'hffff});
    sel = 4'hf;
    rd(5'h04, {16'd400, 16'd0});
    wb(1'b1, 5'h08, 32'h20);
    // dead cell, then low prequal until its time runs out
    expRep.push_back(5'h10);
    wb(1'b1, 5'h00, 32'h1);
    cyc(10);
    chk_cur(chargeCurrentCmd, 8'h04);
    wait_rep(3100);
    battVolt <= 8'h19;
    expRep.push_back(5'h10);
    expRep.push_back(5'h06);
    wait_rep(4300);
    chk_cur(chargeCurrentCmd, 8'h00);
    // leave fault by toggling enable, input gating the restart
    expRep.push_back(5'h18);
    wb(1'b1, 5'h00, 32'h0);
    wait_rep(3100);
    primaryPowerInputValid <= 1'b0;
    battVolt <= 8'h23;
    wb(1'b1, 5'h00, 32'h1);
    cyc(50);
    chk_cur(chargeCurrentCmd, 8'h00);
    expRep.push_back(5'h11);
    primaryPowerInputValid <= 1'b1;
    wait_rep(3100);
    // random target against random supply headroom
    for (n = 0; n < 8; n++) begin
      tgt = 8'($random(seed));
      sysAvail <= 8'($random(seed));
      wb(1'b1, 5'h08, {24'h0, tgt});
      cyc(4);
      chk_cur(chargeCurrentCmd, lo(tgt, sysAvail));
    end
    sysAvail <= 8'hff;
    wb(1'b1, 5'h08, 32'h20);
    // let the cell current settle on the target before regulation
    cyc(4);
    // regulation, termination, top-off and done, then restart
    battVolt <= 8'h30;
    expRep.push_back(5'h12);
    wait_rep(3100);
    expRep.push_back(5'h13);
    expRep.push_back(5'h04);
    wait_rep(10000);
    chk_cur(chargeCurrentCmd, 8'h00);
    battVolt <= 8'h26;
    cyc(8);
    chk_cur(chargeCurrentCmd, 8'h20);
    expRep.push_back(5'h11);
    wait_rep(3100);
    // one fast-charge limit across constant current and voltage
    wb(1'b1, 5'h04, {16'd400, 16'd400});
    battVolt <= 8'h30;
    expRep.push_back(5'h06);
    wait_rep(1200);
    // input removed and reapplied clears the fault
    battVolt <= 8'h23;
    wb(1'b1, 5'h04, {16'd400, 16'd0});
    primaryPowerInputValid <= 1'b0;
    cyc(20);
    expRep.push_back(5'h11);
    primaryPowerInputValid <= 1'b1;
    wait_rep(3100);
    // watchdog expiry, a wrong kick, then a proper kick
    expRep.push_back(5'h0b);
    wb(1'b1, 5'h00, 32'h3);
    wait_rep(300);
    chk_cur(chargeCurrentCmd, 8'h00);
    wb(1'b1, 5'h0c, 32'h2);
    cyc(300);
    expRep.push_back(5'h11);
    wb(1'b1, 5'h0c, 32'h1);
    wb(1'b1, 5'h00, 32'h1);
    wait_rep(3100);
    // thermal stop and return
    expRep.push_back(5'h0a);
    thermalShutdown <= 1'b1;
    wait_rep(20);
    chk_cur(chargeCurrentCmd, 8'h00);
    expRep.push_back(5'h11);
    thermalShutdown <= 1'b0;
    wait_rep(3100);
    finish_test;
  end
endmodule // tb_bcs_charge_fsm
`default_nettype wire
